// ===== verilog/gpio_port.sv
// Port B/C/D data, direction and input registers plus port E overrides.
// Assumes AXI4-Lite on aclk; pins arrive asynchronously, fuses are static.
// Function
// - Oscillator output use of port E bit 2 removes its general I/O use.
// - Port E bit 1 is oscillator input unless internal RC is the clock.
// - Timer 0 compare B drives port E bit 1 only when direction is output.
// - Fuse programmed: port E bit 0 is ordinary I/O.
// - Fuse unprogrammed: port E bit 0 belongs to reset, no I/O.
// - As reset pin, bit 0 direction, latch and input read zero.
// - No pull/direction override; bit 1 value override; bit 2 input gate.
// - Ports B, C, D latch and direction: 8 bits, R/W, reset zero.
// - Input registers have no reset value; they follow pins.
// - Port E registers bits 7..3 read zero; latch, direction reset zero.
// - Port E pins feed pin-change sources 26, 25 and 24.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
module gpio_port #(
  parameter int unsigned PORT_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_pullup,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  output logic [7:0] port_c_pullup,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  output logic [7:0] port_d_pullup,
  input wire logic [2:0] port_e_in,
  output logic [2:0] port_e_out,
  output logic [2:0] port_e_oe,
  output logic [2:0] port_e_pullup,
  input wire logic reset_pin_disable_fuse,
  input wire logic timer0_compare_b_output,
  input wire logic timer0_compare_b_drive_enable,
  input wire logic analog_ch0_digital_disable,
  output logic pin_change_source_26,
  output logic pin_change_source_25,
  output logic pin_change_source_24,
  output logic reset_pin_level
);
  initial begin
    if (PORT_W != 8) $error("PORT_W must be 8");
  end

  logic [7:0] port_b_output_latch, port_b_direction;
  logic [7:0] port_c_output_latch, port_c_direction;
  logic [7:0] port_d_output_latch, port_d_direction;
  logic [2:0] port_e_output_latch, port_e_direction;
  logic [1:0] osc_ctrl;
  logic [26:0] sync1, sync2;
  logic [5:0] aw_addr;
  logic aw_held, w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic fuse_q;
  logic [2:0] e_gpio;
  logic [2:0] e_in_en;
  logic [2:0] e_pin_levels;
  logic [31:0] next_rdata;
  logic do_write;

  // Pin synchroniser; first stage read only by second
  always_ff @(posedge aclk) begin
    sync1 <= {port_e_in, port_d_in, port_c_in, port_b_in};
    sync2 <= sync1;
  end

  // Fuse caught by clock on every edge, in reset too
  always_ff @(posedge aclk) begin
    fuse_q <= reset_pin_disable_fuse;
  end

  // Port E general I/O ownership
  always_comb begin
    e_gpio[gpio_pkg::E_RST_BIT] = fuse_q;
    e_gpio[gpio_pkg::E_OC_BIT] =
      !osc_ctrl[gpio_pkg::CTRL_EXT_CLK];
    e_gpio[gpio_pkg::E_XO_BIT] =
      !osc_ctrl[gpio_pkg::CTRL_XTAL_OUT];
    e_in_en = e_gpio;
    e_in_en[gpio_pkg::E_XO_BIT] = e_gpio[gpio_pkg::E_XO_BIT] &&
      !analog_ch0_digital_disable;
  end

  // Zero when reset pin or input gated off
  assign e_pin_levels = sync2[26:24] & e_in_en;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gpio_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr)
          gpio_pkg::OFF_B_LATCH, gpio_pkg::OFF_B_DIR, gpio_pkg::OFF_B_PIN,
          gpio_pkg::OFF_C_LATCH, gpio_pkg::OFF_C_DIR, gpio_pkg::OFF_C_PIN,
          gpio_pkg::OFF_D_LATCH, gpio_pkg::OFF_D_DIR, gpio_pkg::OFF_D_PIN,
          gpio_pkg::OFF_E_LATCH, gpio_pkg::OFF_E_DIR, gpio_pkg::OFF_E_PIN,
          gpio_pkg::OFF_E_CTRL: s_axi_bresp <= gpio_pkg::RESP_OKAY;
          default: s_axi_bresp <= gpio_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  // Register stores; byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_output_latch <= gpio_pkg::PORT_RESET;
      port_b_direction <= gpio_pkg::PORT_RESET;
      port_c_output_latch <= gpio_pkg::PORT_RESET;
      port_c_direction <= gpio_pkg::PORT_RESET;
      port_d_output_latch <= gpio_pkg::PORT_RESET;
      port_d_direction <= gpio_pkg::PORT_RESET;
      port_e_output_latch <= gpio_pkg::PORT_RESET[2:0];
      port_e_direction <= gpio_pkg::PORT_RESET[2:0];
      osc_ctrl <= gpio_pkg::CTRL_RESET;
    end else if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        gpio_pkg::OFF_B_LATCH: port_b_output_latch <= w_data[7:0];
        gpio_pkg::OFF_B_DIR: port_b_direction <= w_data[7:0];
        gpio_pkg::OFF_C_LATCH: port_c_output_latch <= w_data[7:0];
        gpio_pkg::OFF_C_DIR: port_c_direction <= w_data[7:0];
        gpio_pkg::OFF_D_LATCH: port_d_output_latch <= w_data[7:0];
        gpio_pkg::OFF_D_DIR: port_d_direction <= w_data[7:0];
        gpio_pkg::OFF_E_LATCH: port_e_output_latch <= w_data[2:0];
        gpio_pkg::OFF_E_DIR: port_e_direction <= w_data[2:0];
        gpio_pkg::OFF_E_CTRL: osc_ctrl <= w_data[1:0];
        default: ;
      endcase
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (s_axi_araddr)
      gpio_pkg::OFF_B_LATCH: next_rdata[7:0] = port_b_output_latch;
      gpio_pkg::OFF_B_DIR: next_rdata[7:0] = port_b_direction;
      gpio_pkg::OFF_B_PIN: next_rdata[7:0] = sync2[7:0];
      gpio_pkg::OFF_C_LATCH: next_rdata[7:0] = port_c_output_latch;
      gpio_pkg::OFF_C_DIR: next_rdata[7:0] = port_c_direction;
      gpio_pkg::OFF_C_PIN: next_rdata[7:0] = sync2[15:8];
      gpio_pkg::OFF_D_LATCH: next_rdata[7:0] = port_d_output_latch;
      gpio_pkg::OFF_D_DIR: next_rdata[7:0] = port_d_direction;
      gpio_pkg::OFF_D_PIN: next_rdata[7:0] = sync2[23:16];
      gpio_pkg::OFF_E_LATCH:
        next_rdata[2:0] = port_e_output_latch & {2'b11, fuse_q};
      gpio_pkg::OFF_E_DIR:
        next_rdata[2:0] = port_e_direction & {2'b11, fuse_q};
      gpio_pkg::OFF_E_PIN: next_rdata[2:0] = e_pin_levels;
      gpio_pkg::OFF_E_CTRL: next_rdata[1:0] = osc_ctrl;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= gpio_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      unique case (s_axi_araddr)
        gpio_pkg::OFF_B_LATCH, gpio_pkg::OFF_B_DIR, gpio_pkg::OFF_B_PIN,
        gpio_pkg::OFF_C_LATCH, gpio_pkg::OFF_C_DIR, gpio_pkg::OFF_C_PIN,
        gpio_pkg::OFF_D_LATCH, gpio_pkg::OFF_D_DIR, gpio_pkg::OFF_D_PIN,
        gpio_pkg::OFF_E_LATCH, gpio_pkg::OFF_E_DIR, gpio_pkg::OFF_E_PIN,
        gpio_pkg::OFF_E_CTRL: s_axi_rresp <= gpio_pkg::RESP_OKAY;
        default: s_axi_rresp <= gpio_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Pin drivers, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_out <= gpio_pkg::PORT_RESET;
      port_b_oe <= gpio_pkg::PORT_RESET;
      port_b_pullup <= gpio_pkg::PORT_RESET;
      port_c_out <= gpio_pkg::PORT_RESET;
      port_c_oe <= gpio_pkg::PORT_RESET;
      port_c_pullup <= gpio_pkg::PORT_RESET;
      port_d_out <= gpio_pkg::PORT_RESET;
      port_d_oe <= gpio_pkg::PORT_RESET;
      port_d_pullup <= gpio_pkg::PORT_RESET;
      port_e_out <= gpio_pkg::PORT_RESET[2:0];
      port_e_oe <= gpio_pkg::PORT_RESET[2:0];
      port_e_pullup <= gpio_pkg::PORT_RESET[2:0];
    end else begin
      port_b_out <= port_b_output_latch;
      port_b_oe <= port_b_direction;
      port_b_pullup <= port_b_output_latch & ~port_b_direction;
      port_c_out <= port_c_output_latch;
      port_c_oe <= port_c_direction;
      port_c_pullup <= port_c_output_latch & ~port_c_direction;
      port_d_out <= port_d_output_latch;
      port_d_oe <= port_d_direction;
      port_d_pullup <= port_d_output_latch & ~port_d_direction;
      // Pull-up and direction never overridden; only ownership gates
      port_e_oe <= port_e_direction & e_gpio;
      port_e_pullup <= port_e_output_latch & ~port_e_direction & e_gpio;
      port_e_out <= port_e_output_latch;
      if (timer0_compare_b_drive_enable)
        port_e_out[gpio_pkg::E_OC_BIT] <=
          timer0_compare_b_output;
    end
  end

  // Pin-change sources and reset pin level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_change_source_26 <= 1'b0;
      pin_change_source_25 <= 1'b0;
      pin_change_source_24 <= 1'b0;
      reset_pin_level <= 1'b1;
    end else begin
      pin_change_source_26 <= sync2[26];
      pin_change_source_25 <= sync2[25];
      pin_change_source_24 <= sync2[24];
      reset_pin_level <= fuse_q | sync2[24];
    end
  end
endmodule : gpio_port

// ===== verilog/gpio_pkg.sv
// Package for the port B/C/D/E register block: offsets, widths, resets.
// Assumes a 32-bit AXI4-Lite master on the same clock.
package gpio_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_B_LATCH = 6'h00;
  localparam logic [5:0] OFF_B_DIR = 6'h04;
  localparam logic [5:0] OFF_B_PIN = 6'h08;
  localparam logic [5:0] OFF_C_LATCH = 6'h0C;
  localparam logic [5:0] OFF_C_DIR = 6'h10;
  localparam logic [5:0] OFF_C_PIN = 6'h14;
  localparam logic [5:0] OFF_D_LATCH = 6'h18;
  localparam logic [5:0] OFF_D_DIR = 6'h1C;
  localparam logic [5:0] OFF_D_PIN = 6'h20;
  localparam logic [5:0] OFF_E_LATCH = 6'h24;
  localparam logic [5:0] OFF_E_DIR = 6'h28;
  localparam logic [5:0] OFF_E_PIN = 6'h2C;
  localparam logic [5:0] OFF_E_CTRL = 6'h30;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [2:0] E_MASK = 3'h7;
  localparam int unsigned E_RST_BIT = 0;
  localparam int unsigned E_OC_BIT = 1;
  localparam int unsigned E_XO_BIT = 2;
  // Control register fields
  localparam int unsigned CTRL_XTAL_OUT = 0;
  localparam int unsigned CTRL_EXT_CLK = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpio_pkg

// ===== test/gpio_pins_model.sv
// Pin model: each pin follows its driver while enabled, else the outside.
// Assumes out and oe come registered from the port block.
module gpio_pins_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  assign level = (oe & drv) | (~oe & ext);
endmodule : gpio_pins_model

// ===== test/gpio_port_checker.sv
// Concurrent checks on the gpio_port ports.
// Assumes one clock aclk and synchronous active-low aresetn.
module gpio_port_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] port_e_in,
  input wire logic [2:0] port_e_out,
  input wire logic [2:0] port_e_oe,
  input wire logic reset_pin_disable_fuse,
  input wire logic timer0_compare_b_output,
  input wire logic timer0_compare_b_drive_enable,
  input wire logic pin_change_source_26,
  input wire logic pin_change_source_25,
  input wire logic pin_change_source_24,
  input wire logic reset_pin_level
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write response");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response stuck");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read data");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read data stuck");
  property p_reset;
    !$past(aresetn) |-> port_e_oe == 3'h0 && reset_pin_level;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
  property p_oc;
    timer0_compare_b_drive_enable
      |=> port_e_out[1] == $past(timer0_compare_b_output);
  endproperty
  a_oc: assert property (p_oc) else $error("compare not on pin");
  property p_fuse_io;
    reset_pin_disable_fuse [*3] |-> reset_pin_level;
  endproperty
  a_fuse_io: assert property (p_fuse_io) else $error("reset seen");
  property p_fuse_rst;
    !reset_pin_disable_fuse [*3] |-> !port_e_oe[0];
  endproperty
  a_fuse_rst: assert property (p_fuse_rst) else $error("pin driven");
  property p_pc;
    $stable(port_e_in) [*4] |-> port_e_in ==
      {pin_change_source_26, pin_change_source_25, pin_change_source_24};
  endproperty
  a_pc: assert property (p_pc) else $error("pin change mismatch");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_oc: cover property (timer0_compare_b_drive_enable && port_e_oe[1]);
endmodule : gpio_port_checker
bind gpio_port gpio_port_checker u_chk (.*);

// ===== test/gpio_port_tb.sv
// Bench for gpio_port: AXI4-Lite register tasks and pin models.
// Assumes gpio_pkg offsets and a single 100 MHz clock.
module gpio_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pin_level;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic [7:0] port_b_in, port_b_out, port_b_oe, port_b_pullup, ext_b;
  logic [7:0] port_c_in, port_c_out, port_c_oe, port_c_pullup;
  logic [7:0] port_d_in, port_d_out, port_d_oe, port_d_pullup;
  logic [2:0] port_e_in, port_e_out, port_e_oe, port_e_pullup, ext_e;
  logic reset_pin_disable_fuse, timer0_compare_b_output;
  logic timer0_compare_b_drive_enable, analog_ch0_digital_disable;
  logic pin_change_source_26, pin_change_source_25, pin_change_source_24;
  int n_fail, checks_done, cyc;
  gpio_port DUT (.*);
  gpio_pins_model #(.W(8)) m_b (.drv(port_b_out), .oe(port_b_oe),
    .ext(ext_b), .level(port_b_in));
  gpio_pins_model #(.W(8)) m_c (.drv(port_c_out), .oe(port_c_oe),
    .ext(ext_b), .level(port_c_in));
  gpio_pins_model #(.W(8)) m_d (.drv(port_d_out), .oe(port_d_oe),
    .ext(ext_b), .level(port_d_in));
  gpio_pins_model #(.W(3)) m_e (.drv(port_e_out), .oe(port_e_oe),
    .ext(ext_e), .level(port_e_in));
  always #5 aclk = ~aclk;
  function automatic logic [7:0] val(input int i);
    return 8'h5A ^ 8'(8'h33 * i);
  endfunction : val
  // Port k, register j: 0 latch, 1 direction, 2 pins
  function automatic logic [5:0] off(input int k, input int j);
    return gpio_pkg::OFF_B_LATCH + 6'(12 * k + 4 * j);
  endfunction : off
  task test_done();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    pa = 1'h1;
    pw = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready === 1'h1;
      tw = pw && s_axi_wready === 1'h1;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    @(posedge aclk);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  task rchk(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk("rdata", e, rd_d);
    chk("rresp", {30'h0, gpio_pkg::RESP_OKAY}, {30'h0, rd_r});
  endtask : rchk
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    ext_b = 8'hC3;
    ext_e = 3'h5;
    reset_pin_disable_fuse = 1'h1;
    timer0_compare_b_output = 1'h0;
    timer0_compare_b_drive_enable = 1'h0;
    analog_ch0_digital_disable = 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 8; i++) rchk(off(i / 2, i % 2), 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(off(i / 2, i % 2), {24'hFFFFFF, val(i)});
      rchk(off(i / 2, i % 2), {24'h0, val(i)});
    end
    chk("b_out", {24'h0, val(0)}, {24'h0, port_b_out});
    chk("b_pull", {24'h0, val(0) & ~val(1)}, {24'h0, port_b_pullup});
    for (int k = 0; k < 3; k++) rchk(off(k, 2), {24'h0,
      (val(2 * k) & val(2 * k + 1)) | (ext_b & ~val(2 * k + 1))});
    wr(off(3, 0), 32'hFFFFFFFF);
    wr(off(3, 1), 32'hFFFFFFFF);
    rchk(off(3, 0), 32'h7);
    rchk(off(3, 1), 32'h7);
    rchk(off(3, 2), 32'h7);
    analog_ch0_digital_disable <= 1'h1;
    timer0_compare_b_drive_enable <= 1'h1;
    repeat (4) @(posedge aclk);
    rchk(off(3, 2), 32'h1);
    chk("e_out", 32'h5, {29'h0, port_e_out});
    wr(off(3, 1), 32'h5);
    chk("e_oe", 32'h5, {29'h0, port_e_oe});
    chk("e_pull", 32'h2, {29'h0, port_e_pullup});
    wr(gpio_pkg::OFF_E_CTRL, 32'h3);
    wr(off(3, 1), 32'h7);
    chk("e_oe", 32'h1, {29'h0, port_e_oe});
    analog_ch0_digital_disable <= 1'h0;
    reset_pin_disable_fuse <= 1'h0;
    ext_e <= 3'h3;
    repeat (4) @(posedge aclk);
    chk("e_oe", 32'h0, {29'h0, port_e_oe});
    chk("rst_lvl", 32'h1, {31'h0, reset_pin_level});
    rchk(off(3, 0), 32'h6);
    rchk(off(3, 1), 32'h6);
    rd(off(3, 2));
    chk("e_pin0", 32'h0, {31'h0, rd_d[0]});
    ext_e <= 3'h4;
    repeat (4) @(posedge aclk);
    chk("rst_lvl", 32'h0, {31'h0, reset_pin_level});
    chk("pc_src", 32'h4, {29'h0, pin_change_source_26,
      pin_change_source_25, pin_change_source_24});
    rd(6'h34);
    chk("bad_data", 32'h0, rd_d);
    chk("bad_resp", {30'h0, gpio_pkg::RESP_SLVERR}, {30'h0, rd_r});
    test_done();
  end
endmodule : gpio_port_tb
